// File: common/line_status_cfg.svh
// Offsets, field positions, reset values and constants of the line status block
`ifndef LINE_STATUS_CFG_SVH
`define LINE_STATUS_CFG_SVH

// Register indices (printed offsets not word aligned)
`define LS_IDX_LINE_STATUS   16'hffa5
`define LS_IDX_IRQ_ENABLE    16'hffb0
`define LS_IDX_IRQ_STATUS    16'hffb1
`define LS_IDX_IRQ_MASK      16'hffb2
// Byte address is four times the index
`define LS_ADDR_LINE_STATUS  18'h3_fe94
`define LS_ADDR_IRQ_ENABLE   18'h3_fec0
`define LS_ADDR_IRQ_STATUS   18'h3_fec4
`define LS_ADDR_IRQ_MASK     18'h3_fec8
`define LS_ADDR_W            18

// Line status bit positions
`define LS_BIT_OVR           0
`define LS_BIT_PTE           1
`define LS_BIT_FRE           2
`define LS_BIT_BRK           3
`define LS_BIT_RXF           4
`define LS_BIT_TXE           5
`define LS_BIT_TX_ALL_EMPTY_FLAG          6

// Interrupt enable bits (status, rx, tx)
`define LS_EN_STATUS         0
`define LS_EN_RX             1
`define LS_EN_TX             2

// Reset values and the error clear mask
`define LS_ERR_RESET         4'h0
`define LS_EN_RESET          3'h0
`define LS_IRQ_RESET         3'h0
`define LS_ERR_MASK          4'hf

`endif

// File: common/line_status_pkg.sv
// Types shared by the line status block
package line_status_pkg;

    typedef struct packed {
        logic rx_break_flag;
        logic rx_framing_err_flag;
        logic rx_parity_err_flag;
        logic rx_overrun_flag;
    } rx_err_type;

    typedef struct packed {
        logic rx_full;
        logic tx_hold_empty;
        logic tx_shift_empty;
    } fifo_state_type;

    typedef enum logic [1:0] {
        ACC_IDLE   = 2'b00,
        ACC_SETUP  = 2'b01,
        ACC_ACCESS = 2'b11
    } apb_phase_type;

endpackage : line_status_pkg

// File: hw/err_flag_bank.sv
// Sticky flag bank: set by events, cleared by writing one
`timescale 1ns/1ps
`default_nettype none
module err_flag_bank #(
    parameter int W = 4
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] set_evt,
    input  wire logic [W-1:0] clr_mask,
    output var  logic [W-1:0] flags
);
    logic [W-1:0] next_flags;

    // Set wins over a clear in the same cycle
    assign next_flags = (flags & ~clr_mask) | set_evt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end
endmodule : err_flag_bank
`default_nettype wire

// File: hw/line_status.sv
// Serial line status flags with APB slave, DMA halt and interrupts
//
// Behaviour
// - Any error flag set halts DMA
// - Overrun sets bit 0, resets 0
// - Parity failure sets bit 1
// - Framing bit 2, break bit 3
// - Error flags raise enabled status interrupt
// - Write one clears error flag
// - Bit 5 transmit holding empty, reset 1
// - Bit 6 both transmit registers empty
//
// Chosen here: the APB slave port.
`include "line_status_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module line_status (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Receiver events, one-cycle pulses
    input  wire line_status_pkg::rx_err_type rx_err_evt,
    // Buffer conditions, levels
    input  wire logic        rx_holding_full,
    input  wire logic        tx_holding_empty,
    input  wire logic        tx_shift_empty,
    // Outputs
    output var  logic        dma_halt,
    output var  logic        status_irq_req,
    output var  logic        rx_irq_req,
    output var  logic        tx_irq_req,
    output var  logic        irq
);
    logic [3:0]                     err_flags;
    line_status_pkg::fifo_state_type buf_q;
    logic [2:0]                     irq_enable;
    logic [2:0]                     irq_status;
    logic [2:0]                     irq_mask;
    line_status_pkg::rx_err_type     err_s;

    function automatic logic hit(input logic [31:0] a,
                                 input logic [`LS_ADDR_W-1:0] r);
        hit = (a == {{(32-`LS_ADDR_W){1'b0}}, r});
    endfunction : hit

    // Access decode
    wire setup_ok  = psel & ~penable;
    wire wr_take   = psel & penable & pwrite & pready;
    wire hit_lsr   = hit(paddr, `LS_ADDR_LINE_STATUS);
    wire hit_en    = hit(paddr, `LS_ADDR_IRQ_ENABLE);
    wire hit_ist   = hit(paddr, `LS_ADDR_IRQ_STATUS);
    wire hit_imk   = hit(paddr, `LS_ADDR_IRQ_MASK);
    wire hit_any   = hit_lsr | hit_en | hit_ist | hit_imk;

    // Write-one-to-clear of the error flags
    wire [3:0] err_clr = (wr_take & hit_lsr) ?
                         (pwdata[3:0] & `LS_ERR_MASK) : 4'h0;

    err_flag_bank #(.W(4)) u_err (
        .pclk     (pclk),
        .presetn  (presetn),
        .set_evt  (rx_err_evt),
        .clr_mask (err_clr),
        .flags    (err_flags)
    );
    assign err_s = err_flags;

    wire any_err = |err_flags;

    // Line status read value
    wire [7:0] lsr_val = {1'b0,
                          buf_q.tx_hold_empty & buf_q.tx_shift_empty,
                          buf_q.tx_hold_empty,
                          buf_q.rx_full,
                          err_flags};

    // Interrupt requests
    wire next_status_req = any_err & irq_enable[`LS_EN_STATUS];
    wire next_rx_req = buf_q.rx_full & irq_enable[`LS_EN_RX];
    wire next_tx_req = buf_q.tx_hold_empty & irq_enable[`LS_EN_TX];
    wire [2:0] irq_evt = {next_tx_req, next_rx_req, next_status_req};
    wire [2:0] ist_clr = (wr_take & hit_ist) ? pwdata[2:0] : 3'h0;
    wire [2:0] next_irq_status = (irq_status & ~ist_clr) | irq_evt;
    wire       next_irq = |(next_irq_status & irq_mask);

    wire [31:0] rd_mux =
        hit_lsr ? {24'h00_0000, lsr_val} :
        hit_en  ? {29'h0000_0000, irq_enable} :
        hit_ist ? {29'h0000_0000, irq_status} :
        hit_imk ? {29'h0000_0000, irq_mask} : 32'h0000_0000;

    // Buffer state, transmit flags reset to empty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_q <= 3'b011;
        end else begin
            buf_q <= {rx_holding_full, tx_holding_empty, tx_shift_empty};
        end
    end

    // APB answers in the first access cycle, with no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup_ok;
            pslverr <= setup_ok & ~hit_any;
            prdata  <= (setup_ok & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Software control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable <= `LS_EN_RESET;
            irq_mask   <= `LS_IRQ_RESET;
            irq_status <= `LS_IRQ_RESET;
        end else begin
            if (wr_take & hit_en) begin
                irq_enable <= pwdata[2:0];
            end
            if (wr_take & hit_imk) begin
                irq_mask <= pwdata[2:0];
            end
            irq_status <= next_irq_status;
        end
    end

    // Registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_halt       <= 1'b0;
            status_irq_req <= 1'b0;
            rx_irq_req     <= 1'b0;
            tx_irq_req     <= 1'b0;
            irq            <= 1'b0;
        end else begin
            dma_halt       <= |(err_flags & ~err_clr) | (|rx_err_evt);
            status_irq_req <= next_status_req;
            rx_irq_req     <= next_rx_req;
            tx_irq_req     <= next_tx_req;
            irq            <= next_irq;
        end
    end

    // Checks
    a_halt_follows_flags: assert property (@(posedge pclk) disable iff (!presetn)
        dma_halt == (|err_flags))
        else $error("dma halt does not follow error flags");

    a_ovr_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
        rx_err_evt.rx_overrun_flag |=> err_s.rx_overrun_flag)
        else $error("overrun event lost");

    a_pte_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
        rx_err_evt.rx_parity_err_flag |=> err_s.rx_parity_err_flag)
        else $error("parity event lost");

    a_fre_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
        rx_err_evt.rx_framing_err_flag |=> err_s.rx_framing_err_flag)
        else $error("framing event lost");

    a_brk_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
        rx_err_evt.rx_break_flag |=> err_s.rx_break_flag)
        else $error("break event lost");

    sequence s_setup_seen;
        psel & ~penable;
    endsequence

    sequence s_access_answer;
        pready;
    endsequence

    a_apb_answer_next: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup_seen |=> s_access_answer)
        else $error("no answer after setup cycle");

    a_apb_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        (s_setup_seen and (!hit_any)) |=> pslverr)
        else $error("unmapped access without error");

    a_irq_from_mask: assert property (@(posedge pclk) disable iff (!presetn)
        irq == $past(|(next_irq_status & irq_mask)))
        else $error("interrupt line does not follow mask");

    a_status_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (any_err & irq_enable[`LS_EN_STATUS]) |=> status_irq_req)
        else $error("status request missing");

    sequence s_clear_write;
        wr_take & hit_lsr & pwdata[0] & ~rx_err_evt.rx_overrun_flag;
    endsequence

    a_clear_one_works: assert property (@(posedge pclk) disable iff (!presetn)
        s_clear_write |=> !err_s.rx_overrun_flag)
        else $error("write one did not clear overrun");

    a_zero_keeps_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (err_s.rx_parity_err_flag & !(wr_take & hit_lsr & pwdata[1])) |=> err_s.rx_parity_err_flag)
        else $error("parity flag lost without clear");

    a_tx_all_empty_flag_implies_txe: assert property (@(posedge pclk) disable iff (!presetn)
        lsr_val[`LS_BIT_TX_ALL_EMPTY_FLAG] |-> lsr_val[`LS_BIT_TXE])
        else $error("all empty without holding empty");

    a_tx_req_gate: assert property (@(posedge pclk) disable iff (!presetn)
        tx_irq_req |-> $past(buf_q.tx_hold_empty))
        else $error("tx request without empty holding");

    a_bit7_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (pready & hit_lsr & ~pwrite) |-> !prdata[7])
        else $error("reserved bit reads one");

endmodule : line_status
`default_nettype wire

// File: test/serial_side_model.sv
// Receiver and transmitter side model: error pulses and buffer levels
`timescale 1ns/1ps
`default_nettype none
module serial_side_model (
    input  wire logic                        pclk,
    output var  line_status_pkg::rx_err_type rx_err_evt,
    output var  logic                        rx_holding_full,
    output var  logic                        tx_holding_empty,
    output var  logic                        tx_shift_empty
);
    initial begin
        rx_err_evt       = '0;
        rx_holding_full  = 1'b0;
        tx_holding_empty = 1'b1;
        tx_shift_empty   = 1'b1;
    end
    // One-cycle receive error pulse
    task automatic pulse(input logic [3:0] e);
        @(posedge pclk);
        rx_err_evt <= line_status_pkg::rx_err_type'(e);
        @(posedge pclk);
        rx_err_evt <= '0;
    endtask : pulse
    task automatic levels(input logic r, input logic h, input logic s);
        @(posedge pclk);
        rx_holding_full  <= r;
        tx_holding_empty <= h;
        tx_shift_empty   <= s;
    endtask : levels
endmodule : serial_side_model
`default_nettype wire

// File: test/line_status_tb_top.sv
// Self-checking bench for the line status block
`include "line_status_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module line_status_tb_top;
    localparam logic [31:0] A_LS  = {14'h0000, `LS_ADDR_LINE_STATUS};
    localparam logic [31:0] A_EN  = {14'h0000, `LS_ADDR_IRQ_ENABLE};
    localparam logic [31:0] A_IS  = {14'h0000, `LS_ADDR_IRQ_STATUS};
    localparam logic [31:0] A_IM  = {14'h0000, `LS_ADDR_IRQ_MASK};
    localparam logic [31:0] A_BAD = 32'h0000_0100;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] paddr   = 32'h0000_0000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, dma_halt, st_irq, rx_irq, tx_irq, irq;
    logic        rx_holding_full_flag, txh, txs;
    logic [3:0]  e;
    logic [2:0]  b;
    logic [32:0] exp_q[$];
    int          errors    = 0;
    int          tests_run = 0;
    line_status_pkg::rx_err_type evt;

    always #20 pclk = ~pclk;

    line_status dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_err_evt(evt), .rx_holding_full(rx_holding_full_flag), .tx_holding_empty(txh),
        .tx_shift_empty(txs), .dma_halt(dma_halt), .status_irq_req(st_irq),
        .rx_irq_req(rx_irq), .tx_irq_req(tx_irq), .irq(irq));
    serial_side_model far (.pclk(pclk), .rx_err_evt(evt),
        .rx_holding_full(rx_holding_full_flag), .tx_holding_empty(txh), .tx_shift_empty(txs));

    task automatic conclude();
        $display("tests_run %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task automatic cmp_bus(input logic [32:0] x, input logic [32:0] g);
        tests_run++;
        if (g !== x) begin
            errors++;
            $display("[FAIL] %0t bus exp %h got %h", $time, x, g);
        end
    endtask : cmp_bus
    task automatic cmp_lvl(input logic [4:0] x, input logic [4:0] g);
        tests_run++;
        if (g !== x) begin
            errors++;
            $display("[FAIL] %0t lvl exp %h got %h", $time, x, g);
        end
    endtask : cmp_lvl
    // Halt, status, rx, tx requests and irq after settling
    task automatic lvl(input logic [4:0] x);
        repeat (4) @(posedge pclk);
        cmp_lvl(x, {dma_halt, st_irq, rx_irq, tx_irq, irq});
    endtask : lvl
    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [31:0] d, input logic [32:0] x);
        int n;
        n = 0;
        exp_q.push_back(x);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            errors++;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Oldest expected answer against each completed transfer
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            if (exp_q.size() == 0)
                errors++;
            else
                cmp_bus(exp_q.pop_front(), {pslverr, prdata});
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        conclude();
    end

    initial begin
        void'($urandom(32'h9b94ac11));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, A_LS, 0, 33'h0_0000_0060);
        lvl(5'b00000);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            far.pulse(4'h1 << i);
            lvl(5'b10000);
            apb(1, A_LS, 0, 0);
            apb(0, A_LS, 0, 33'h60 | (33'h1 << i));
            apb(1, A_LS, 32'h1 << i, 0);
            apb(0, A_LS, 0, 33'h0_0000_0060);
            lvl(5'b00000);
            $display("test error bit %0d done", i);
        end
        e = 4'h1 << ($urandom % 4);
        apb(1, A_EN, 1, 0);
        apb(1, A_IM, 1, 0);
        far.pulse(e);
        lvl(5'b11001);
        apb(0, A_IS, 0, 33'h0_0000_0001);
        apb(1, A_LS, {28'h000_0000, e}, 0);
        apb(1, A_IS, 1, 0);
        lvl(5'b00000);
        $display("test status interrupt done");
        apb(1, A_EN, 32'h0000_0006, 0);
        for (int k = 0; k < 8; k++) begin
            b = k[2:0];
            far.levels(b[2], b[1], b[0]);
            apb(0, A_LS, 0, {25'h000_0000, b[1] & b[0], b[1], b[2], 4'h0});
            lvl({2'b00, b[2], b[1], 1'b0});
        end
        apb(1, A_LS, 32'h0000_00ff, 0);
        apb(0, A_LS, 0, 33'h0_0000_0070);
        $display("test buffer flags done");
        apb(1, A_BAD, 32'hffff_ffff, 33'h1_0000_0000);
        apb(0, A_BAD, 0, 33'h1_0000_0000);
        $display("test unmapped done");
        conclude();
    end
endmodule : line_status_tb_top
`default_nettype wire
